// >>> shared/cci_pkg.sv
// constants, types and helper functions for the converter current interlock
package cci_pkg;

   localparam int NCONV  = 8;
   localparam int CW     = 16;
   localparam int CYC_AW = 5;
   localparam int CONV_AW = 3;
   localparam int MEM_AW = CYC_AW + CONV_AW;
   localparam int NGROUP = 2;

   // group membership of each converter, bit set means group 1
   localparam logic [NCONV-1:0] GROUP_MAP = 8'hf0;

   // arbitrary unlock key for the reference loading procedure
   localparam logic [15:0] LOAD_KEY = 16'hc3a5;

   // tolerance limits in tenths of a percent
   localparam logic [15:0] TOL_DEN         = 16'd1000;
   localparam logic [9:0]  TOL_BUMPER_LIM  = 10'd10;
   localparam logic [9:0]  TOL_MAIN_LIM    = 10'd1;
   localparam logic [9:0]  TOL_OTHER_MIN   = 10'd1;
   localparam logic [9:0]  TOL_OTHER_LIM   = 10'd5;

   // measurement resolution is one count; tolerance must span this many
   localparam logic [CW-1:0] ACC_FACTOR_MIN = 16'd3;
   localparam logic [CW-1:0] ACC_FACTOR_MAX = 16'd4;

   // mains transient detection timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int MAINS_PERIOD_MS = 20;
   localparam int DETECT_PERIODS  = 2;
   localparam int MAINS_TIMEOUT_CYC =
      (MAINS_PERIOD_MS * 1000000 / CLK_PERIOD_NS) * DETECT_PERIODS;
   localparam int TMO_W = 23;

   typedef enum logic [1:0] {
      CLS_BUMPER,
      CLS_MAIN,
      CLS_OTHER
   } cci_class_t;

   typedef struct packed {
      logic cycle_start;
      logic warn;
      logic win_start;
      logic win_end;
      logic extract;
   } cci_evt_t;

   typedef struct packed {
      logic [15:0] cycle_num;
      logic [7:0]  beam_id;
      logic [3:0]  beam_type;
      logic [3:0]  particle;
      logic        ring;
      logic [5:0]  batches;
   } cci_cycinfo_t;

   typedef struct packed {
      logic          mask;
      cci_class_t    cls;
      logic [CW-1:0] nom;
      logic [CW-1:0] tol;
   } cci_ref_t;

   typedef struct packed {
      logic misfire;
      logic pfn_charged;
      logic trigger;
      logic local_mode;
      logic sync_ok;
      logic energy_ok;
   } cci_kick_t;

   function automatic logic cci_out_of_tol(input logic [CW-1:0] meas,
                                           input logic [CW-1:0] nom,
                                           input logic [CW-1:0] tol);
      logic [CW-1:0] diff;
      diff = (meas > nom) ? (meas - nom) : (nom - meas);
      return diff > tol;
   endfunction

   function automatic logic cci_tol_ok(input cci_ref_t r);
      logic [25:0] lhs;
      logic [25:0] rhs;
      logic [9:0]  lim;
      lhs = 26'(r.tol) * 26'(TOL_DEN);
      case (r.cls)
         CLS_BUMPER: lim = TOL_BUMPER_LIM;
         CLS_MAIN:   lim = TOL_MAIN_LIM;
         default:    lim = TOL_OTHER_LIM;
      endcase
      rhs = 26'(r.nom) * 26'(lim);
      return (lhs <= rhs) && (r.tol >= ACC_FACTOR_MIN) && (r.cls != 2'(3));
   endfunction

endpackage

// >>> design/cci_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module cci_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // cci_sync

// >>> design/cci_ref_mem.sv
// reference store: nominal, tolerance, class and mask per cycle and converter
`timescale 1ns/1ps
module cci_ref_mem
   import cci_pkg::*;
(
   // clock
   input  wire logic              clk,
   // write port
   input  wire logic              we,
   input  wire logic [MEM_AW-1:0] waddr,
   input  cci_ref_t               wdata,
   // read port
   input  wire logic [MEM_AW-1:0] raddr,
   output cci_ref_t               rdata
);
   // no reset on the array so contents survive a logic reset
   cci_ref_t mem [2**MEM_AW];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // cci_ref_mem

// >>> design/cci_interlock.sv
// converter current surveillance with main converter and kicker interlocks
`timescale 1ns/1ps
module cci_interlock
   import cci_pkg::*;
#(
   parameter int MAINS_TIMEOUT = MAINS_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // timing system pins
   input  cci_evt_t                      evt,
   input  cci_cycinfo_t                  cycinfo,
   // converter measurement, same clock
   input  wire logic [NCONV-1:0][CW-1:0] meas,
   input  wire logic                     meas_valid,
   // converter and plant pins
   input  wire logic [NCONV-1:0]         conv_fault,
   input  wire logic                     main_conv_on,
   input  wire logic                     mains_zero_cross,
   input  wire logic                     extract_req,
   input  wire logic                     beam_dumped,
   input  wire logic                     beam_out_seg,
   input  cci_kick_t                     kick,
   // reference loading, same clock
   input  wire logic                     load_unlock,
   input  wire logic [15:0]              load_key,
   input  wire logic                     load_we,
   input  wire logic [MEM_AW-1:0]        load_addr,
   input  cci_ref_t                      load_data,
   output logic                          load_ack_r,
   output logic                          load_err_r,
   // permits and interlocks
   output logic [NGROUP-1:0]             enable_r,
   output logic                          dump_req_r,
   output logic                          slow_ok_r,
   output logic                          fast_ok_r,
   output logic                          kick_dump_r,
   output logic                          pfn_discharge_r,
   output logic                          local_inhibit_r,
   output logic                          kick_ok_r,
   output logic [15:0]                   cycle_num_r
);

   localparam int SW = $bits(cci_evt_t) + $bits(cci_cycinfo_t) + NCONV + 5
                       + $bits(cci_kick_t);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOAD,
      ST_ARMED,
      ST_WINDOW,
      ST_EVAL,
      ST_DONE
   } cci_state_t;

   // synchronised pin levels
   cci_evt_t           evt_s;
   cci_cycinfo_t       info_s;
   logic [NCONV-1:0]   fault_s;
   logic               main_on_s;
   logic               zc_s;
   logic               req_s;
   logic               dumped_s;
   logic               beam_out_s;
   cci_kick_t          kick_s;

   cci_sync #(
      .W (SW)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({evt, cycinfo, conv_fault, main_conv_on, mains_zero_cross,
             extract_req, beam_dumped, beam_out_seg, kick}),
      .q   ({evt_s, info_s, fault_s, main_on_s, zc_s,
             req_s, dumped_s, beam_out_s, kick_s})
   );

   // edge detection on synchronised events
   cci_evt_t evt_prev_r;
   cci_evt_t evt_rise;
   logic     zc_prev_r;
   logic     zc_rise;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_prev_r <= '0;
         zc_prev_r  <= 1'b0;
      end else begin
         evt_prev_r <= evt_s;
         zc_prev_r  <= zc_s;
      end
   end

   assign evt_rise = evt_s & ~evt_prev_r;
   assign zc_rise  = zc_s & ~zc_prev_r;

   // state machine and reference fetch
   cci_state_t           state_r;
   logic [CONV_AW:0]     ld_cnt_r;
   logic [CYC_AW-1:0]    cfg_idx_r;
   cci_ref_t             ref_r [NCONV];
   cci_ref_t             mem_rdata;
   logic [MEM_AW-1:0]    mem_raddr;
   logic                 mem_we;

   assign mem_raddr = {cfg_idx_r, ld_cnt_r[CONV_AW-1:0]};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r   <= ST_IDLE;
         ld_cnt_r  <= '0;
         cfg_idx_r <= '0;
      end else if (evt_rise.cycle_start) begin
         state_r   <= ST_LOAD;
         ld_cnt_r  <= '0;
         cfg_idx_r <= info_s.beam_id[CYC_AW-1:0];
      end else begin
         case (state_r)
            ST_IDLE: state_r <= ST_IDLE;
            ST_LOAD: begin
               ld_cnt_r <= ld_cnt_r + 1'b1;
               if (ld_cnt_r == (CONV_AW+1)'(NCONV)) begin
                  state_r <= ST_ARMED;
               end
            end
            ST_ARMED: if (evt_rise.win_start) begin
               state_r <= ST_WINDOW;
            end
            ST_WINDOW: if (evt_rise.win_end) begin
               state_r <= ST_EVAL;
            end
            ST_EVAL: state_r <= ST_DONE;
            ST_DONE: state_r <= ST_DONE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // capture one reference entry per cycle, one read behind the address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCONV; i++) begin
            ref_r[i] <= '0;
         end
      end else if (state_r == ST_LOAD && ld_cnt_r != '0) begin
         ref_r[ld_cnt_r[CONV_AW-1:0] - 1'b1] <= mem_rdata;
      end
   end

   cci_ref_mem u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (load_addr),
      .wdata (load_data),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   // protected loading of references
   logic unlocked_r;
   logic busy;

   assign busy   = (state_r == ST_LOAD) || (state_r == ST_WINDOW);
   assign mem_we = load_we && unlocked_r && !busy && cci_tol_ok(load_data);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unlocked_r <= 1'b0;
         load_ack_r <= 1'b0;
         load_err_r <= 1'b0;
      end else begin
         load_ack_r <= mem_we;
         if (load_we) begin
            unlocked_r <= 1'b0;
            if (!mem_we) begin
               load_err_r <= 1'b1;
            end
         end else if (load_unlock && load_key == LOAD_KEY) begin
            unlocked_r <= 1'b1;
            load_err_r <= 1'b0;
         end
      end
   end

   // per converter window checks
   logic [NCONV-1:0] fail_r;
   logic [NCONV-1:0] seen_r;
   logic [NCONV-1:0] sel;

   always_comb begin
      for (int i = 0; i < NCONV; i++) begin
         sel[i] = ref_r[i].mask;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fail_r <= '0;
         seen_r <= '0;
      end else if (evt_rise.cycle_start || state_r == ST_ARMED) begin
         fail_r <= '0;
         seen_r <= '0;
      end else if (state_r == ST_WINDOW) begin
         for (int i = 0; i < NCONV; i++) begin
            if (fault_s[i]) begin
               fail_r[i] <= 1'b1;
            end else if (meas_valid &&
                         cci_out_of_tol(meas[i], ref_r[i].nom, ref_r[i].tol)) begin
               fail_r[i] <= 1'b1;
            end
            if (meas_valid) begin
               seen_r[i] <= 1'b1;
            end
         end
      end
   end

   // group permits
   logic [NGROUP-1:0] grp_pass;
   logic [NGROUP-1:0] grp_fault;

   always_comb begin
      for (int g = 0; g < NGROUP; g++) begin
         grp_pass[g]  = 1'b0;
         grp_fault[g] = 1'b0;
      end
      for (int g = 0; g < NGROUP; g++) begin
         for (int i = 0; i < NCONV; i++) begin
            if (sel[i] && (GROUP_MAP[i] == g[0])) begin
               grp_pass[g] = 1'b1;
               grp_fault[g] = grp_fault[g] | fault_s[i];
            end
         end
      end
      for (int g = 0; g < NGROUP; g++) begin
         for (int i = 0; i < NCONV; i++) begin
            if (sel[i] && (GROUP_MAP[i] == g[0]) && (fail_r[i] || !seen_r[i])) begin
               grp_pass[g] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_r <= '0;
      end else if (evt_rise.cycle_start) begin
         enable_r <= '0;
      end else if (state_r == ST_EVAL) begin
         enable_r <= grp_pass & ~grp_fault;
      end else begin
         enable_r <= enable_r & ~grp_fault;
      end
   end

   // extraction moment watch
   logic ext_armed_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_armed_r <= 1'b0;
         dump_req_r  <= 1'b0;
         cycle_num_r <= '0;
      end else if (evt_rise.cycle_start) begin
         ext_armed_r <= 1'b0;
         dump_req_r  <= 1'b0;
         cycle_num_r <= info_s.cycle_num;
      end else begin
         if (evt_rise.extract) begin
            ext_armed_r <= 1'b0;
         end else if ((evt_rise.warn || ext_armed_r) && req_s) begin
            ext_armed_r <= 1'b1;
         end
         if (ext_armed_r && !req_s && !evt_rise.extract) begin
            dump_req_r <= 1'b1;
            ext_armed_r <= 1'b0;
         end
      end
   end

   // main ring converter signals
   logic [TMO_W-1:0] mains_cnt_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_ok_r   <= 1'b0;
         fast_ok_r   <= 1'b0;
         mains_cnt_r <= '0;
      end else begin
         slow_ok_r <= main_on_s;
         if (zc_rise) begin
            mains_cnt_r <= '0;
            fast_ok_r   <= 1'b1;
         end else if (mains_cnt_r >= TMO_W'(MAINS_TIMEOUT)) begin
            fast_ok_r <= 1'b0;
         end else begin
            mains_cnt_r <= mains_cnt_r + 1'b1;
         end
      end
   end

   // kicker interlocks
   logic trig_seen_r;
   logic discharged_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         kick_dump_r     <= 1'b0;
         local_inhibit_r <= 1'b1;
         kick_ok_r       <= 1'b0;
      end else begin
         kick_dump_r     <= kick_s.misfire;
         local_inhibit_r <= kick_s.local_mode;
         kick_ok_r       <= kick_s.sync_ok & kick_s.energy_ok;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_seen_r     <= 1'b0;
         discharged_r    <= 1'b0;
         pfn_discharge_r <= 1'b0;
      end else if (evt_rise.cycle_start) begin
         trig_seen_r     <= 1'b0;
         discharged_r    <= 1'b0;
         pfn_discharge_r <= 1'b0;
      end else begin
         if (kick_s.trigger) begin
            trig_seen_r <= 1'b1;
         end
         pfn_discharge_r <= 1'b0;
         if (kick_s.pfn_charged && !trig_seen_r && !kick_s.trigger && dumped_s &&
             beam_out_s && !discharged_r) begin
            pfn_discharge_r <= 1'b1;
            discharged_r    <= 1'b1;
         end
      end
   end

endmodule // cci_interlock

// >>> test/cci_interlock_sva.sv
// port assertions for the converter current interlock
`timescale 1ns/1ps
module cci_interlock_sva
   import cci_pkg::*;
#(
   parameter int MAINS_TIMEOUT = MAINS_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // timing and plant pins
   input cci_evt_t               evt,
   input wire logic              main_conv_on,
   input wire logic              mains_zero_cross,
   input wire logic              extract_req,
   input wire logic              beam_dumped,
   input wire logic              beam_out_seg,
   input cci_kick_t              kick,
   input wire logic              load_we,
   // outputs
   input logic                   load_ack_r,
   input logic [NGROUP-1:0]      enable_r,
   input logic                   dump_req_r,
   input logic                   slow_ok_r,
   input logic                   fast_ok_r,
   input logic                   kick_dump_r,
   input logic                   pfn_discharge_r,
   input logic                   local_inhibit_r,
   input logic                   kick_ok_r
);
   int   zc_cnt_r;
   logic zc_prev_r;

   // cycles since the last mains crossing pin edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zc_cnt_r  <= 0;
         zc_prev_r <= 1'b0;
      end else begin
         zc_prev_r <= mains_zero_cross;
         zc_cnt_r  <= (mains_zero_cross && !zc_prev_r) ? 0 : zc_cnt_r + 1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   start_clear_a: assert property (
      $rose(evt.cycle_start) |-> ##3 (enable_r == '0 && !dump_req_r))
      else $error("permit or dump left set after cycle start");
   permit_source_a: assert property (
      ($rose(enable_r[0]) || $rose(enable_r[1])) |-> $past(evt.win_end, 4))
      else $error("permit raised without window end");
   slow_off_a: assert property (
      (!main_conv_on) [*5] |-> !slow_ok_r)
      else $error("slow signal permitted while converters off");
   slow_on_a: assert property (
      main_conv_on [*5] |-> slow_ok_r)
      else $error("slow signal dropped without fault");
   fast_drop_a: assert property (
      $fell(fast_ok_r) |-> zc_cnt_r >= MAINS_TIMEOUT)
      else $error("fast signal dropped too early");
   fast_timeout_a: assert property (
      zc_cnt_r > MAINS_TIMEOUT + 6 |-> !fast_ok_r)
      else $error("fast signal kept after mains loss");
   misfire_dump_a: assert property (
      kick.misfire [*4] |-> kick_dump_r)
      else $error("misfire gave no dump request");
   local_inhibit_a: assert property (
      kick.local_mode [*4] |-> local_inhibit_r)
      else $error("local mode gave no inhibit");
   kick_health_a: assert property (
      (!(kick.sync_ok && kick.energy_ok)) [*4] |-> !kick_ok_r)
      else $error("kicker health bad but reported good");
   pfn_pulse_a: assert property (
      pfn_discharge_r |-> ($past(beam_dumped, 3) && $past(beam_out_seg, 3)) ##1 !pfn_discharge_r)
      else $error("network discharge without dump or too long");
   load_ack_a: assert property (
      load_ack_r |-> $past(load_we) ##1 !load_ack_r)
      else $error("load acknowledge without write");
   dump_cause_a: assert property (
      $rose(dump_req_r) |-> !$past(extract_req, 3))
      else $error("dump raised while extraction requested");
endmodule // cci_interlock_sva

bind cci_interlock cci_interlock_sva #(.MAINS_TIMEOUT(MAINS_TIMEOUT)) i_cci_interlock_sva (
   .clk(clk), .rst(rst), .evt(evt), .main_conv_on(main_conv_on),
   .mains_zero_cross(mains_zero_cross), .extract_req(extract_req),
   .beam_dumped(beam_dumped), .beam_out_seg(beam_out_seg), .kick(kick), .load_we(load_we),
   .load_ack_r(load_ack_r), .enable_r(enable_r), .dump_req_r(dump_req_r),
   .slow_ok_r(slow_ok_r), .fast_ok_r(fast_ok_r), .kick_dump_r(kick_dump_r),
   .pfn_discharge_r(pfn_discharge_r), .local_inhibit_r(local_inhibit_r),
   .kick_ok_r(kick_ok_r));

// >>> test/cci_timing_model.sv
// timing system model playing event pins and cycle identity
`timescale 1ns/1ps
module cci_timing_model
   import cci_pkg::*;
(
   // clock
   input wire logic clk,
   // timing pins
   output cci_evt_t     evt,
   output cci_cycinfo_t cycinfo
);
   initial begin
      evt     = '0;
      cycinfo = '0;
   end

   // one event pin high for four clocks, then idle
   task automatic ev(input int b, input int gap);
      @(posedge clk) #1 evt[b] = 1'b1;
      repeat (4) @(posedge clk);
      #1 evt[b] = 1'b0;
      repeat (gap) @(posedge clk);
      #1;
   endtask

   // cycle start with identity, identity inverted afterwards
   task automatic start(input logic [7:0] id, input logic [15:0] num);
      cycinfo = '{num, id, 4'h1, 4'h2, 1'b1, 6'h0c};
      ev(4, 16);
      cycinfo = ~cycinfo;
   endtask

   // warning, optional window and extraction events
   task automatic win(input logic w, input logic x);
      ev(3, 6);
      if (w) begin
         ev(2, 20);
         ev(1, 4);
      end
      if (x) ev(0, 4);
   endtask
endmodule // cci_timing_model

// >>> test/cci_interlock_tb_top.sv
// self-checking bench for the converter current interlock
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %h seen %h", n, e, s); end end
module cci_interlock_tb_top
   import cci_pkg::*;
;
   localparam logic [15:0] NOM = 16'h4000;
   localparam logic [1:0]  TC [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h3};
   localparam logic [15:0] TT [8] = '{16'h00a3, 16'h00a4, 16'h0010, 16'h0011,
                                      16'h0051, 16'h0052, 16'h0002, 16'h0010};
   localparam logic [1:0]  TE [8] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2};
   typedef struct {string nm; int s; logic [15:0] v;} cci_note_t;

   logic clk, rst, meas_valid, main_conv_on, mains_zero_cross, extract_req;
   logic beam_dumped, beam_out_seg, load_unlock, load_we, chk, zc_run;
   logic load_ack_r, load_err_r, dump_req_r, slow_ok_r, fast_ok_r, kick_dump_r;
   logic pfn_discharge_r, local_inhibit_r, kick_ok_r;
   logic [NGROUP-1:0]         enable_r;
   logic [15:0]               cycle_num_r, load_key;
   logic [NCONV-1:0][CW-1:0]  meas;
   logic [NCONV-1:0]          conv_fault;
   logic [MEM_AW-1:0]         load_addr;
   cci_ref_t                  load_data;
   cci_kick_t                 kick;
   cci_evt_t                  evt;
   cci_cycinfo_t              cycinfo;
   cci_note_t                 exp_q[$];
   cci_note_t                 nt;
   int                        num_errors, check_count, pfn_cnt, num;
   int                        off [NCONV];
   logic [31:0]               lf = 32'h0000_2814;

   cci_interlock #(.MAINS_TIMEOUT(50)) i_cci_interlock (
      .clk(clk), .rst(rst), .evt(evt), .cycinfo(cycinfo), .meas(meas),
      .meas_valid(meas_valid), .conv_fault(conv_fault), .main_conv_on(main_conv_on),
      .mains_zero_cross(mains_zero_cross), .extract_req(extract_req),
      .beam_dumped(beam_dumped), .beam_out_seg(beam_out_seg), .kick(kick),
      .load_unlock(load_unlock), .load_key(load_key), .load_we(load_we),
      .load_addr(load_addr), .load_data(load_data), .load_ack_r(load_ack_r),
      .load_err_r(load_err_r), .enable_r(enable_r), .dump_req_r(dump_req_r),
      .slow_ok_r(slow_ok_r), .fast_ok_r(fast_ok_r), .kick_dump_r(kick_dump_r),
      .pfn_discharge_r(pfn_discharge_r), .local_inhibit_r(local_inhibit_r),
      .kick_ok_r(kick_ok_r), .cycle_num_r(cycle_num_r));
   cci_timing_model i_cci_timing_model (.clk(clk), .evt(evt), .cycinfo(cycinfo));

   function automatic logic [31:0] lfsr();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction

   function automatic logic [15:0] pick(int s);
      case (s)
         0: return 16'(enable_r);
         1: return 16'(dump_req_r);
         2: return cycle_num_r;
         3: return 16'({load_err_r, load_ack_r});
         4: return 16'({slow_ok_r, fast_ok_r, kick_dump_r, local_inhibit_r, kick_ok_r});
         default: return 16'(pfn_cnt);
      endcase
   endfunction

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // result watcher: oldest note against the outputs
   always @(posedge clk) begin
      if (pfn_discharge_r === 1'b1) pfn_cnt++;
      if (chk === 1'b1) begin
         nt = exp_q.pop_front();
         `CHK(nt.nm, nt.v, pick(nt.s))
      end
   end

   // converter currents, jittered inside tolerance unless offset
   always @(posedge clk) begin
      #1;
      for (int i = 0; i < NCONV; i++)
         meas[i] = (off[i] != 0) ? 16'(NOM + off[i]) : 16'(NOM + int'(lfsr() % 33) - 16);
   end

   // mains crossings every 23 clocks while running
   initial begin
      mains_zero_cross = 1'b0;
      forever begin
         repeat (20) @(posedge clk);
         #1 mains_zero_cross = zc_run;
         repeat (3) @(posedge clk);
         #1 mains_zero_cross = 1'b0;
      end
   end

   task automatic note(input string nm, input int s, input logic [15:0] v);
      exp_q.push_back('{nm, s, v});
      chk = 1'b1;
      @(posedge clk) #1 chk = 1'b0;
      @(posedge clk) #1;
   endtask

   task automatic load(input logic [7:0] a, input cci_ref_t d, input logic [15:0] k,
                       input logic [1:0] e);
      @(posedge clk) #1 load_unlock = 1'b1;
      load_key = k;
      @(posedge clk) #1 load_unlock = 1'b0;
      {load_we, load_addr, load_data} = {1'b1, a, d};
      @(posedge clk) #1 load_we = 1'b0;
      note("load", 3, 16'(e));
   endtask

   task automatic run(input logic [7:0] id, input logic [1:0] en, input logic w, x);
      num++;
      extract_req = 1'b1;
      i_cci_timing_model.start(id, 16'(num));
      note("en_clr", 0, 16'h0000);
      note("dump_clr", 1, 16'h0000);
      note("cycnum", 2, 16'(num));
      i_cci_timing_model.win(w, x);
      note("enable", 0, 16'(en));
      extract_req = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      note("dump", 1, 16'(!x));
   endtask

   task automatic plant(input logic [5:0] v, input int w, input logic [4:0] e);
      {main_conv_on, zc_run, kick.misfire, kick.local_mode, kick.sync_ok, kick.energy_ok} = v;
      repeat (w) @(posedge clk);
      #1;
      note("plant", 4, 16'(e));
   endtask

   task automatic done(input string t);
      $display("test %s done, errors %0d", t, num_errors);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      {chk, extract_req, beam_dumped, beam_out_seg, load_unlock, load_we} = '0;
      {meas_valid, main_conv_on, zc_run} = 3'h7;
      {kick, conv_fault, load_key, load_addr, load_data} = '0;
      {kick.sync_ok, kick.energy_ok} = 2'h3;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 16; i++)
         load(8'((i / 8 + 1) * 8 + i % 8), '{i != 13, CLS_MAIN, NOM, 16'h0010}, LOAD_KEY, 2'h1);
      for (int i = 0; i < 8; i++)
         load(8'h18, '{1'b1, cci_class_t'(TC[i]), NOM, TT[i]}, LOAD_KEY, TE[i]);
      load(8'h18, '{1'b1, CLS_MAIN, NOM, 16'h0010}, ~LOAD_KEY, 2'h2);
      done("load");
      run(8'h01, 2'h3, 1'b1, 1'b1);
      off[2] = -16;
      off[6] = 17;
      run(8'h01, 2'h1, 1'b1, 1'b1);
      off[2] = 0;
      off[6] = 0;
      conv_fault = 8'h02;
      run(8'h01, 2'h2, 1'b1, 1'b1);
      conv_fault = '0;
      off[5] = 500;
      run(8'h02, 2'h3, 1'b1, 1'b1);
      off[5] = 0;
      run(8'h01, 2'h0, 1'b0, 1'b0);
      run(8'h01, 2'h3, 1'b1, 1'b1);
      done("cycles");
      {kick.pfn_charged, beam_out_seg} = 2'h3;
      repeat (20) @(posedge clk);
      #1;
      note("pfn_hold", 5, 16'h0000);
      beam_dumped = 1'b1;
      repeat (30) @(posedge clk);
      #1;
      note("pfn", 5, 16'h0001);
      plant(6'b110011, 8, 5'b11001);
      plant(6'b010011, 8, 5'b01001);
      plant(6'b111011, 8, 5'b11101);
      plant(6'b110111, 8, 5'b11011);
      plant(6'b110001, 8, 5'b11000);
      plant(6'b110010, 8, 5'b11000);
      plant(6'b100011, 70, 5'b10001);
      plant(6'b110011, 40, 5'b11001);
      done("plant");
      tally_and_finish();
   end
endmodule // cci_interlock_tb_top
